//--- design/hippc_pkg.sv
// Purpose: constants and types for the indexed host port pointer/config block
// Assumes: 5-bit host byte address, 16-bit data pins
// Notes: offsets are byte addresses of the indexed map
package hippc_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_PTR = 3;
  localparam logic [4:0] OFS_PTR0 = 5'h00;
  localparam logic [4:0] OFS_PTR1 = 5'h08;
  localparam logic [4:0] OFS_PTR2 = 5'h10;
  localparam logic [4:0] OFS_CFG = 5'h1C;
  localparam logic [15:0] PTR_RESET = 16'h1234;
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam int unsigned CFG_FIFO_BIT = 3;
  localparam int unsigned CFG_COPY_STRIDE = 8;
  localparam logic [31:0] PTR_USED_MASK = 32'h0000FFFF;
  localparam logic [31:0] CFG_USED_MASK = 32'h0F0F0F0F;
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    HIPPC_IDLE = 2'b00,
    HIPPC_WRITE = 2'b01,
    HIPPC_READ = 2'b10
  } hippc_phase_t;

  typedef struct packed {
    logic csN;
    logic wrN;
    logic rdN;
    logic busEnableStrobeN;
    logic rdWr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } hippc_pins_t;

  typedef struct packed {
    logic [DATA_W-1:0] dataOut;
    logic [DATA_W-1:0] dataOe;
  } hippc_drive_t;
endpackage

//--- design/hippc_sync.sv
// Purpose: two-flop synchroniser for the host pin bundle
// Assumes: pins are asynchronous to clock
// Notes: first stage is read only by the second stage
`timescale 1ns/1ns
module hippc_sync #(
  parameter int unsigned WIDTH = 28
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] resetValue,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } hippc_sync_state_t;

  hippc_sync_state_t state;
  hippc_sync_state_t next_state;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("hippc_sync width must be positive");
    end
  end

  always_comb
  begin
    next_state.first = async;
    next_state.second = state.first;
    if (srst)
    begin
      next_state.first = resetValue;
      next_state.second = resetValue;
    end
  end

  always_ff @(posedge clock)
  begin
    state <= next_state;
  end

  assign synced = state.second;
endmodule

//--- design/hippc_host_port.sv
// Purpose: pointer and byte-order configuration registers of the indexed host port
// Assumes: strobes active low; pins pass two flops; 8/16-bit mode chosen by a port
// Notes: data-register assembly, FIFO access and live locking live elsewhere
// Notes on behaviour
// - host bus 8 or 16 bits; 32-bit registers accessed in byte or word pieces
// - pointer bits 15:0 hold internal address; bits 31:16 reserved, read-only
// - pointer address is always a byte address whatever the bus width
// - pointer address resets to 1234h so host can infer byte order
// - each byte or word write takes effect alone, no dword assembly
// - config bit 3 sets direct FIFO byte order, 1 big endian, reset 0
// - config bits 0..2 set byte order of pointer/data sets 0..2
// - FIFO order bit copied at 3, 11, 19, 27; a one anywhere sets all
// - pair bit n copied at n+8, n+16, n+24; reserved nibbles read-only
// - write cycle is chip select with write strobe, or enable with direction write
// - write data captured on the trailing edge of the write cycle
// - written lane chosen from register byte order and low address bits
// - after initialization writes are ignored until a read cycle occurs
// - during and after low power, writes ignored until a read completes
// - read cycle is chip select with read strobe, or enable with direction read
// - at read start the addressed register drives a byte or word on pins; code leaves the pins undriven in low power
// - returned lane chosen from register byte order and low address bits
// - 8-bit mode uses five address bits as byte address; 16-bit drops bit 0
// - three independent pointer registers, one per pointer/data pair
`timescale 1ns/1ns
module hippc_host_port (
  input wire logic clock,
  input wire logic srst,
  input wire logic wideMode,
  input wire logic fullPowerState,
  input wire hippc_pkg::hippc_pins_t pins,
  output hippc_pkg::hippc_drive_t drive,
  output logic [15:0] pointerAddr0,
  output logic [15:0] pointerAddr1,
  output logic [15:0] pointerAddr2,
  output logic [3:0] byteOrder,
  output logic writesEnabled
);
  import hippc_pkg::*;

  localparam int unsigned PINS_W = $bits(hippc_pins_t);

  typedef struct packed {
    hippc_phase_t phase;
    logic [NUM_PTR-1:0][15:0] ptr;
    logic [3:0] order;
    logic unlocked;
    logic [DATA_W-1:0] dataOut;
    logic [DATA_W-1:0] dataOe;
    // address and data of the write cycle, sampled while its strobe is seen active and held after
    logic [ADDR_W-1:0] wrAddr;
    logic [DATA_W-1:0] wrData;
  } hippc_state_t;

  hippc_state_t state;
  hippc_state_t next_state;
  hippc_pins_t pinSync;
  hippc_pins_t pinIdle;
  logic writeActive;
  logic readActive;
  logic [1:0] lane;
  logic [31:0] regValue;
  logic [31:0] regMerged;
  logic [15:0] readPiece;
  logic [ADDR_W-1:0] effAddr;
  logic [1:0] wrLane;
  logic [2:0] wrIdx;

  initial
  begin
    if (NUM_PTR != 3 || DATA_W != 16 || ADDR_W != 5)
    begin
      $error("hippc_host_port sizes do not match the register map");
    end
  end

  always_comb
  begin
    pinIdle = '0;
    pinIdle.csN = 1'b1;
    pinIdle.wrN = 1'b1;
    pinIdle.rdN = 1'b1;
    pinIdle.busEnableStrobeN = 1'b1;
    pinIdle.rdWr = 1'b1;
  end

  // every host pin, address and data included, passes two flops before use
  hippc_sync #(
    .WIDTH(PINS_W)
  ) u_sync (
    .clock(clock),
    .srst(srst),
    .resetValue(pinIdle),
    .async(pins),
    .synced(pinSync)
  );

  // register index: 0..2 pointers, 3 config, else unmapped
  function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
    logic [4:0] base;
    base = {a[4:2], 2'b00};
    case (base)
      OFS_PTR0: decode = 3'h0;
      OFS_PTR1: decode = 3'h1;
      OFS_PTR2: decode = 3'h2;
      OFS_CFG: decode = 3'h3;
      default: decode = 3'h7;
    endcase
  endfunction

  // byte lane within the dword; big endian mirrors the lane
  function automatic logic [1:0] pickLane(input logic [ADDR_W-1:0] a, input logic big,
    input logic wide);
    logic [1:0] l;
    l = wide ? {a[1], 1'b0} : a[1:0];
    if (big)
    begin
      l = wide ? {~a[1], 1'b0} : ~a[1:0];
    end
    pickLane = l;
  endfunction

  function automatic logic [31:0] cfgSpread(input logic [3:0] o);
    cfgSpread = {4'h0, o, 4'h0, o, 4'h0, o, 4'h0, o};
  endfunction

  function automatic logic orderOf(input logic [2:0] idx, input logic [3:0] o);
    orderOf = (idx < 3'h3) ? o[idx[1:0]] : 1'b0;
  endfunction

  // dword image of a register as the host sees it
  function automatic logic [31:0] regImage(input logic [2:0] idx, input logic [NUM_PTR-1:0][15:0] p,
    input logic [3:0] o);
    case (idx)
      3'h0: regImage = {16'h0000, p[0]};
      3'h1: regImage = {16'h0000, p[1]};
      3'h2: regImage = {16'h0000, p[2]};
      3'h3: regImage = cfgSpread(o) & CFG_USED_MASK;
      default: regImage = 32'h00000000;
    endcase
  endfunction

  assign effAddr = wideMode ? {pinSync.addr[4:1], 1'b0} : pinSync.addr;

  assign writeActive = (!pinSync.csN && !pinSync.wrN) ||
    (!pinSync.csN && !pinSync.busEnableStrobeN && !pinSync.rdWr);
  assign readActive = (!pinSync.csN && !pinSync.rdN) ||
    (!pinSync.csN && !pinSync.busEnableStrobeN && pinSync.rdWr);

  // read path: register and lane come straight from the synchronised address
  always_comb
  begin
    logic [2:0] idx;
    idx = decode(effAddr);
    regValue = regImage(idx, state.ptr, state.order);
    lane = pickLane(effAddr, orderOf(idx, state.order), wideMode);
    readPiece = wideMode ? regValue[lane*8 +: 16] : {8'h00, regValue[lane*8 +: 8]};
  end

  // write path uses address and data held from the last sample with the strobe still active;
  // the host may let both go together with the strobe
  always_comb
  begin
    wrIdx = decode(state.wrAddr);
    wrLane = pickLane(state.wrAddr, orderOf(wrIdx, state.order), wideMode);
    regMerged = regImage(wrIdx, state.ptr, state.order);
    if (wideMode)
    begin
      regMerged[wrLane*8 +: 16] = state.wrData;
    end
    else
    begin
      regMerged[wrLane*8 +: 8] = state.wrData[7:0];
    end
  end

  // cycle tracking: a cycle is taken when seen from idle, a write lands when it ends
  always_comb
  begin
    logic [2:0] idx;
    logic [3:0] setBits;
    idx = wrIdx;
    setBits = 4'h0;
    next_state = state;
    next_state.dataOe = {DATA_W{1'b1}};
    if (writeActive)
    begin
      next_state.wrAddr = effAddr;
      next_state.wrData = pinSync.data;
    end
    case (state.phase)
      HIPPC_IDLE:
      begin
        if (readActive)
        begin
          next_state.phase = HIPPC_READ;
        end
        else if (writeActive)
        begin
          next_state.phase = HIPPC_WRITE;
        end
      end
      HIPPC_WRITE:
      begin
        if (!writeActive)
        begin
          next_state.phase = HIPPC_IDLE;
          if (state.unlocked && fullPowerState)
          begin
            case (idx)
              3'h0, 3'h1, 3'h2:
              begin
                next_state.ptr[idx[1:0]] = regMerged[15:0] & PTR_USED_MASK[15:0];
              end
              3'h3:
              begin
                setBits = regMerged[3:0] | regMerged[11:8] | regMerged[19:16] | regMerged[27:24];
                next_state.order = setBits;
              end
              default:
              begin
                next_state.order = state.order;
              end
            endcase
          end
        end
      end
      HIPPC_READ:
      begin
        if (fullPowerState)
        begin
          next_state.dataOut = readPiece;
          next_state.dataOe = wideMode ? 16'h0000 : 16'hFF00;
        end
        if (!readActive)
        begin
          next_state.phase = HIPPC_IDLE;
          next_state.dataOe = {DATA_W{1'b1}};
          if (fullPowerState)
          begin
            next_state.unlocked = 1'b1;
          end
        end
      end
      default:
      begin
        next_state.phase = HIPPC_IDLE;
      end
    endcase
    if (!fullPowerState)
    begin
      next_state.unlocked = 1'b0;
    end
    if (srst)
    begin
      next_state.phase = HIPPC_IDLE;
      next_state.ptr = {NUM_PTR{PTR_RESET}};
      next_state.order = CFG_RESET;
      next_state.unlocked = 1'b0;
      next_state.dataOut = '0;
      next_state.dataOe = {DATA_W{1'b1}};
      next_state.wrAddr = '0;
      next_state.wrData = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    state <= next_state;
  end

  assign drive.dataOut = state.dataOut;
  assign drive.dataOe = state.dataOe;
  assign pointerAddr0 = state.ptr[0];
  assign pointerAddr1 = state.ptr[1];
  assign pointerAddr2 = state.ptr[2];
  assign byteOrder = state.order;
  assign writesEnabled = state.unlocked;

  a_reset_pointer: assert property (@(posedge clock)
    srst |=> state.ptr[0] == PTR_RESET && state.order == 4'h0)
    else $error("pointer or order not at reset value");
  a_locked_no_write: assert property (@(posedge clock) disable iff (srst)
    (state.phase == HIPPC_WRITE && !writeActive && !state.unlocked) |=> $stable(state.ptr) && $stable(state.order))
    else $error("write accepted while locked");
  a_lowpower_lock: assert property (@(posedge clock) disable iff (srst)
    !fullPowerState |=> !state.unlocked)
    else $error("writes not locked in low power");
  a_read_unlocks: assert property (@(posedge clock) disable iff (srst)
    (state.phase == HIPPC_READ && !readActive && fullPowerState) |=> state.unlocked)
    else $error("completed read did not unlock");
  a_write_trailing: assert property (@(posedge clock) disable iff (srst)
    (state.phase != HIPPC_WRITE || writeActive) |=> $stable(state.ptr))
    else $error("pointer changed outside write trailing edge");
  a_read_drives: assert property (@(posedge clock) disable iff (srst)
    (state.phase == HIPPC_READ && readActive && fullPowerState) |=> state.dataOe[7:0] == 8'h00)
    else $error("read did not drive data");
  a_idle_release: assert property (@(posedge clock) disable iff (srst)
    (state.phase == HIPPC_IDLE && !readActive) |=> state.dataOe == 16'hFFFF)
    else $error("data driven outside read");
  a_cfg_wide_zero: assert property (@(posedge clock) disable iff (srst)
    (state.phase == HIPPC_READ && readActive && fullPowerState && decode(effAddr) == 3'h3) |=>
      (state.dataOut & 16'hF0F0) == 16'h0000)
    else $error("reserved config bits not zero");
  a_ptr_upper_zero: assert property (@(posedge clock) disable iff (srst)
    (state.phase == HIPPC_READ && readActive && fullPowerState && decode(effAddr) < 3'h3 && lane[1]) |=>
      state.dataOut == 16'h0000)
    else $error("reserved pointer bits not zero");
  a_narrow_byte: assert property (@(posedge clock) disable iff (srst)
    (state.phase == HIPPC_READ && readActive && fullPowerState && !wideMode) |=>
      state.dataOe == 16'hFF00 && state.dataOut[15:8] == 8'h00)
    else $error("byte read not on low lane");
  a_wide_word: assert property (@(posedge clock) disable iff (srst)
    (state.phase == HIPPC_READ && readActive && fullPowerState && wideMode) |=> state.dataOe == 16'h0000)
    else $error("word read not on both lanes");
  a_lowpower_quiet: assert property (@(posedge clock) disable iff (srst)
    !fullPowerState |=> state.dataOe == 16'hFFFF && $stable(state.ptr) && $stable(state.order))
    else $error("low power state drove data or took a write");
  a_order_trailing: assert property (@(posedge clock) disable iff (srst)
    (state.phase != HIPPC_WRITE || writeActive) |=> $stable(state.order))
    else $error("byte order changed outside write trailing edge");
  a_write_quiet: assert property (@(posedge clock) disable iff (srst)
    state.phase == HIPPC_WRITE |=> state.dataOe == 16'hFFFF)
    else $error("data driven during write");
  a_unlock_after_read: assert property (@(posedge clock) disable iff (srst)
    $rose(state.unlocked) |-> $past(state.phase) == HIPPC_READ)
    else $error("writes unlocked without a read");
  a_write_then_idle: assert property (@(posedge clock) disable iff (srst)
    state.phase == HIPPC_WRITE |=> state.phase != HIPPC_READ)
    else $error("read taken before write cycle ended");
endmodule

//--- sim/hippc_host_model.sv
// Purpose: host processor bus model for the indexed host port
// Assumes: strobes active low, changed at the falling edge
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ns
module hippc_host_model (
  input wire logic clock,
  input wire hippc_pkg::hippc_drive_t drive,
  output hippc_pkg::hippc_pins_t pins
);
  import hippc_pkg::*;
  hippc_pins_t hostPins;
  logic hostOe;
  initial
  begin
    hostPins = '{csN: 1'b1, wrN: 1'b1, rdN: 1'b1, busEnableStrobeN: 1'b1, rdWr: 1'b1, addr: 5'h00, data: 16'h0000};
    hostOe = 1'b0;
  end
  always_comb
  begin
    pins = hostPins;
    pins.data = (~drive.dataOe & drive.dataOut) | (drive.dataOe & (hostOe ? hostPins.data : ~hostPins.data));
  end
  // one bus cycle; strobe held at least 4 clocks, then idle 6 clocks
  task automatic cycle(input logic rd, input logic alt, input logic [4:0] a, input logic [15:0] d,
                       output logic [15:0] q, output logic ok);
    int n;
    n = 0;
    @(negedge clock);
    hostPins.addr = a;
    hostPins.data = d;
    hostPins.rdWr = rd;
    hostPins.csN = 1'b0;
    hostOe = !rd;
    if (alt)
      hostPins.busEnableStrobeN = 1'b0;
    else if (rd)
      hostPins.rdN = 1'b0;
    else
      hostPins.wrN = 1'b0;
    repeat (3) @(negedge clock);
    while (rd && drive.dataOe[7:0] !== 8'h00 && n < 12)
    begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    q = pins.data;
    ok = !rd || (drive.dataOe[7:0] === 8'h00);
    hostPins = '{csN: 1'b1, wrN: 1'b1, rdN: 1'b1, busEnableStrobeN: 1'b1, rdWr: rd, addr: a, data: d};
    hostOe = 1'b0;
    repeat (6) @(negedge clock);
  endtask
endmodule

//--- sim/tb.sv
// Purpose: self-checking bench of the indexed host port registers
// Assumes: host model drives the pins; inputs change at the falling edge
// Notes: 8-bit reads compare the low byte only
`timescale 1ns/1ns
`define CHK(what, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("ERROR %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb;
  import hippc_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic wideMode = 1'b0;
  logic fullPowerState = 1'b1;
  hippc_pins_t pins;
  hippc_drive_t drive;
  logic [15:0] pointerAddr0;
  logic [15:0] pointerAddr1;
  logic [15:0] pointerAddr2;
  logic [3:0] byteOrder;
  logic writesEnabled;
  logic [15:0] q;
  logic ok;
  int n_fail = 0;
  int total_checks = 0;
  always #50 clock = ~clock;
  hippc_host_port u_hippc_host_port (
    .clock(clock),
    .srst(srst),
    .wideMode(wideMode),
    .fullPowerState(fullPowerState),
    .pins(pins),
    .drive(drive),
    .pointerAddr0(pointerAddr0),
    .pointerAddr1(pointerAddr1),
    .pointerAddr2(pointerAddr2),
    .byteOrder(byteOrder),
    .writesEnabled(writesEnabled)
  );
  hippc_host_model u_hippc_host_model (
    .clock(clock),
    .drive(drive),
    .pins(pins)
  );
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic rd(input logic alt, input logic [4:0] a, input logic [15:0] exp);
    u_hippc_host_model.cycle(1'b1, alt, a, 16'h0000, q, ok);
    `CHK("read answered", 1'b1, ok)
    `CHK("read data", exp, q & (wideMode ? 16'hFFFF : 16'h00FF))
  endtask
  task automatic wr(input logic alt, input logic [4:0] a, input logic [15:0] d);
    u_hippc_host_model.cycle(1'b0, alt, a, d, q, ok);
  endtask
  task automatic t_reset();
    `CHK("ptr0", 16'h1234, pointerAddr0)
    `CHK("order", 4'h0, byteOrder)
    wr(1'b0, 5'h00, 16'h0077);
    `CHK("ptr0 locked", 16'h1234, pointerAddr0)
    rd(1'b0, 5'h00, 16'h0034);
    rd(1'b0, 5'h01, 16'h0012);
    rd(1'b0, 5'h02, 16'h0000);
    `CHK("unlocked", 1'b1, writesEnabled)
  endtask
  task automatic t_byte();
    wr(1'b0, 5'h08, 16'h00AB);
    `CHK("ptr1", 16'h12AB, pointerAddr1)
    wr(1'b0, 5'h0A, 16'h0055);
    `CHK("ptr1 rsvd", 16'h12AB, pointerAddr1)
    rd(1'b1, 5'h09, 16'h0012);
    `CHK("ptr2", 16'h1234, pointerAddr2)
  endtask
  task automatic t_cfg();
    wr(1'b1, 5'h1D, 16'h0002);
    `CHK("order", 4'h2, byteOrder)
    rd(1'b0, 5'h1F, 16'h0002);
    rd(1'b0, 5'h08, 16'h0000);
    rd(1'b0, 5'h0B, 16'h00AB);
    wr(1'b0, 5'h0A, 16'h00CD);
    `CHK("ptr1 be", 16'hCDAB, pointerAddr1)
    wr(1'b0, 5'h1C, 16'h0008);
    `CHK("fifo order", 4'hA, byteOrder)
  endtask
  task automatic t_wide();
    wideMode = 1'b1;
    wr(1'b1, 5'h10, 16'hBEEF);
    `CHK("ptr2", 16'hBEEF, pointerAddr2)
    rd(1'b0, 5'h12, 16'h0000);
    rd(1'b0, 5'h10, 16'hBEEF);
  endtask
  task automatic t_power();
    fullPowerState = 1'b0;
    repeat (3) @(negedge clock);
    wr(1'b0, 5'h10, 16'h1111);
    fullPowerState = 1'b1;
    repeat (3) @(negedge clock);
    `CHK("relocked", 1'b0, writesEnabled)
    wr(1'b0, 5'h10, 16'h2222);
    `CHK("ptr2 kept", 16'hBEEF, pointerAddr2)
    rd(1'b0, 5'h10, 16'hBEEF);
    wr(1'b0, 5'h10, 16'h3333);
    `CHK("ptr2 new", 16'h3333, pointerAddr2)
  endtask
  initial
  begin
    repeat (2) @(negedge clock);
    srst = 1'b0;
    @(negedge clock);
    t_reset();
    t_byte();
    t_cfg();
    t_wide();
    t_power();
    stop_test();
  end
endmodule
